//--- serial_port_pkg.sv
// Purpose: shared constants, types and register map of the serial port channel
// Assumes: 25 MHz system clock, 32-bit register port
// Notes: bit period counts below 4096 cycles are overridden through the top parameter
package serial_port_pkg;

    localparam int CLOCK_HZ = 25_000_000;
    localparam int BAUD_PORT_ONE = 1200;
    localparam int BAUD_PORT_FOUR = 9600;
    localparam logic [15:0] PORT_ONE_BIT_CYCLES = 16'(CLOCK_HZ / BAUD_PORT_ONE);
    localparam logic [15:0] PORT_FOUR_BIT_CYCLES = 16'(CLOCK_HZ / BAUD_PORT_FOUR);

    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int BUS_W = 32;

    // register byte offsets
    localparam logic [7:0] REG_TX_DATA = 8'h00;
    localparam logic [7:0] REG_RX_DATA = 8'h04;
    localparam logic [7:0] REG_CONFIG = 8'h08;
    localparam logic [7:0] REG_BAUD = 8'h0c;
    localparam logic [7:0] REG_MODEM = 8'h10;
    localparam logic [7:0] REG_RTS_DELAY = 8'h14;
    localparam logic [7:0] REG_WATERMARK = 8'h18;
    localparam logic [7:0] REG_STATUS = 8'h1c;

    // field positions
    localparam int MODE_MSB = 2;
    localparam int WM_LOW_LSB = 0;
    localparam int WM_HIGH_LSB = 2;
    localparam int MODEM_RTS = 0;
    localparam int MODEM_CTS = 1;
    localparam int MODEM_CD = 2;
    localparam int MODEM_MANUAL = 3;
    localparam int ST_TX_READY = 0;
    localparam int ST_RX_VALID = 1;
    localparam int ST_TX_BUSY = 2;
    localparam int ST_OVERRUN = 3;
    localparam int ST_FRAME_ERR = 4;
    localparam int ST_RX_FILL_LSB = 5;

    // reset values and limits
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam logic [1:0] WM_LOW_RESET = 2'h1;
    localparam logic [1:0] WM_HIGH_RESET = 2'h1;
    localparam logic [15:0] RTS_DELAY_RESET = 16'h0000;
    localparam logic [2:0] MODE_CODE_MAX = 3'h6;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // two-entry buffer fill codes
    localparam logic [1:0] BUF_EMPTY = 2'h0;
    localparam logic [1:0] BUF_ONE = 2'h1;
    localparam logic [1:0] BUF_FULL = 2'h2;

    typedef enum logic [2:0] {
        MODE_NONE = 3'h0,
        MODE_MANUAL = 3'h1,
        MODE_AUTO_CTS = 3'h2,
        MODE_AUTO_RTS = 3'h3,
        MODE_FULL_AUTO = 3'h4,
        MODE_DYNAMIC = 3'h5,
        MODE_ENHANCED = 3'h6
    } flow_mode_type;

    typedef enum logic [1:0] {
        TX_IDLE = 2'h0,
        TX_START = 2'h1,
        TX_DATA = 2'h2,
        TX_STOP = 2'h3
    } tx_state_type;

    typedef enum logic [1:0] {
        RX_IDLE = 2'h0,
        RX_START = 2'h1,
        RX_DATA = 2'h2,
        RX_STOP = 2'h3
    } rx_state_type;

    typedef struct packed {
        logic rxd;
        logic cts;
        logic cd;
    } line_type;

    localparam line_type LINE_IDLE = 3'h4;

    typedef struct packed {
        logic [DATA_W-1:0] e0;
        logic [DATA_W-1:0] e1;
        logic [1:0] cnt;
    } buffer_state_type;

    typedef struct packed {
        line_type s1;
        line_type s2;
        line_type s3;
        line_type line;
        logic [2:0] mode;
        logic [15:0] bit_cycles;
        logic [15:0] rts_delay;
        logic [1:0] wm_low;
        logic [1:0] wm_high;
        logic manual;
        logic prog_rts;
        logic rts_auto;
        logic [15:0] delay_cnt;
        logic rts_wm;
        logic rts;
        logic txd;
        tx_state_type tx_state;
        logic [15:0] tx_cnt;
        logic [2:0] tx_bit;
        logic [DATA_W-1:0] tx_shift;
        rx_state_type rx_state;
        logic [15:0] rx_cnt;
        logic [2:0] rx_bit;
        logic [DATA_W-1:0] rx_shift;
        logic rx_push;
        logic [DATA_W-1:0] rx_byte;
        logic overrun;
        logic frame_err;
        logic [BUS_W-1:0] rd_data;
    } port_state_type;

endpackage

//--- two_entry_buffer.sv
// Purpose: two-entry byte buffer with valid/ready on both sides
// Assumes: single clock, asynchronous active-low reset
// Notes: pushing while full is refused through in_ready
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer (
    input wire logic sys_clk, // system clock
    input wire logic arst_n, // async reset, active low
    input wire logic in_valid, // fill side offers a byte
    output logic in_ready, // buffer can take a byte
    input wire logic [serial_port_pkg::DATA_W-1:0] in_data, // byte in
    output logic out_valid, // byte available
    input wire logic out_ready, // drain side takes the byte
    output logic [serial_port_pkg::DATA_W-1:0] out_data, // oldest byte
    output logic [1:0] fill // entries held
);
    serial_port_pkg::buffer_state_type s;
    serial_port_pkg::buffer_state_type next_s;
    logic push;
    logic pop;

    assign push = in_valid && (s.cnt != serial_port_pkg::BUF_FULL);
    assign pop = out_ready && (s.cnt != serial_port_pkg::BUF_EMPTY);

    always_comb begin
        next_s = s;
        case ({push, pop})
            2'h2: begin
                if (s.cnt == serial_port_pkg::BUF_EMPTY) begin
                    next_s.e0 = in_data;
                end else begin
                    next_s.e1 = in_data;
                end
                next_s.cnt = s.cnt + serial_port_pkg::BUF_ONE;
            end
            2'h1: begin
                next_s.e0 = s.e1;
                next_s.cnt = s.cnt - serial_port_pkg::BUF_ONE;
            end
            2'h3: begin
                if (s.cnt == serial_port_pkg::BUF_ONE) begin
                    next_s.e0 = in_data;
                end else begin
                    next_s.e0 = s.e1;
                    next_s.e1 = in_data;
                end
            end
            default: begin
                next_s = s;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign in_ready = (s.cnt != serial_port_pkg::BUF_FULL);
    assign out_valid = (s.cnt != serial_port_pkg::BUF_EMPTY);
    assign out_data = s.e0;
    assign fill = s.cnt;
endmodule // two_entry_buffer
`default_nettype wire

//--- serial_port_flow_control.sv
// Purpose: one asynchronous serial port channel with selectable flow control mode
// Assumes: CTS, CD and receive line are active high logic levels after level shifting
// Notes: instantiate once per port; override reset_bit_cycles for the fourth port
//
// How it works
// - Port one comes out of reset at 1200 baud, 8 data bits, one stop bit, no parity, no pause, no echo.
// - Port four comes out of reset at 9600 baud, 8N1, no pause, software flow option left off.
// - A programmed baud rate and mode replace the reset defaults, each port on its own.
// - Mode 0 treats CTS and CD as asserted so reception is always enabled.
// - Mode 0 raises RTS on a write before sending and drops it after the last character leaves.
// - In mode 0 the first RTS command from software switches the port to manual behaviour for good.
// - Mode 1 sends and receives ignoring the lines, drives RTS only from software, and shows CTS and CD.
// - Mode 2 sends only while CTS is high, treats CD as asserted, and leaves RTS to software.
// - Mode 3 treats CTS and CD as asserted and raises RTS on a write until transmission ends.
// - In modes 3 and 4 software RTS holds until released, and a release waits for the buffer to drain.
// - In modes 3 and 4 the RTS release after the last character waits a programmable delay.
// - Mode 4 takes received characters only while CD is high.
// - Mode 4 raises RTS on a write, waits for CTS to send, and drops RTS when done.
// - Mode 5 uses fixed buffers, sends while CTS is high, and drives RTS from receive fill watermarks.
// - Mode 6 joins modes 0 and 2: automatic RTS on writes, sending gated by CTS, software RTS kept.
`timescale 1ns/1ps
`default_nettype none
module serial_port_flow_control #(
    parameter logic [15:0] reset_bit_cycles = serial_port_pkg::PORT_ONE_BIT_CYCLES
) (
    input wire logic sys_clk, // system clock
    input wire logic arst_n, // async reset, active low
    input wire logic [serial_port_pkg::ADDR_W-1:0] addr, // register byte address
    input wire logic [serial_port_pkg::BUS_W-1:0] wr_data, // write data
    input wire logic wr_stb, // write strobe
    input wire logic rd_stb, // read strobe
    output logic [serial_port_pkg::BUS_W-1:0] rd_data, // read data, cycle after rd_stb
    input wire logic rxd, // serial receive pin
    input wire logic cts, // clear to send from the DCE
    input wire logic cd, // carrier detect from the DCE
    output logic txd, // serial transmit pin
    output logic rts // request to send to the DCE
);
    localparam serial_port_pkg::port_state_type PORT_RESET = '{
        s1: serial_port_pkg::LINE_IDLE,
        s2: serial_port_pkg::LINE_IDLE,
        s3: serial_port_pkg::LINE_IDLE,
        line: serial_port_pkg::LINE_IDLE,
        mode: serial_port_pkg::MODE_RESET,
        bit_cycles: reset_bit_cycles,
        rts_delay: serial_port_pkg::RTS_DELAY_RESET,
        wm_low: serial_port_pkg::WM_LOW_RESET,
        wm_high: serial_port_pkg::WM_HIGH_RESET,
        txd: 1'b1,
        tx_state: serial_port_pkg::TX_IDLE,
        rx_state: serial_port_pkg::RX_IDLE,
        default: '0
    };

    serial_port_pkg::port_state_type s;
    serial_port_pkg::port_state_type next_s;
    serial_port_pkg::flow_mode_type eff;

    logic auto_mode;
    logic cts_ok;
    logic cd_ok;
    logic tx_take;
    logic tx_in_valid;
    logic tx_in_ready;
    logic tx_out_valid;
    logic [serial_port_pkg::DATA_W-1:0] tx_out_data;
    logic rx_in_ready;
    logic rx_out_valid;
    logic rx_pop;
    logic [serial_port_pkg::DATA_W-1:0] rx_out_data;
    logic [1:0] rx_fill;

    function automatic serial_port_pkg::flow_mode_type decode_mode(input logic [2:0] code, input logic manual);
        serial_port_pkg::flow_mode_type e;
        e = (code > serial_port_pkg::MODE_CODE_MAX) ? serial_port_pkg::MODE_NONE
                                                    : serial_port_pkg::flow_mode_type'(code);
        if (manual && (e == serial_port_pkg::MODE_NONE)) begin
            e = serial_port_pkg::MODE_MANUAL;
        end
        return e;
    endfunction

    assign eff = decode_mode(s.mode, s.manual);

    // modes whose driver raises RTS by itself on a write
    assign auto_mode = (eff == serial_port_pkg::MODE_NONE) || (eff == serial_port_pkg::MODE_AUTO_RTS)
                       || (eff == serial_port_pkg::MODE_FULL_AUTO) || (eff == serial_port_pkg::MODE_ENHANCED);

    assign cts_ok = ((eff == serial_port_pkg::MODE_AUTO_CTS) || (eff == serial_port_pkg::MODE_FULL_AUTO)
                     || (eff == serial_port_pkg::MODE_DYNAMIC) || (eff == serial_port_pkg::MODE_ENHANCED))
                    ? s.line.cts : 1'b1;

    assign cd_ok = (eff == serial_port_pkg::MODE_FULL_AUTO) ? s.line.cd : 1'b1;

    // in automatic modes RTS must already stand before the start bit goes out
    assign tx_take = (s.tx_state == serial_port_pkg::TX_IDLE) && tx_out_valid && cts_ok
                     && (!auto_mode || s.rts_auto);

    assign tx_in_valid = wr_stb && (addr == serial_port_pkg::REG_TX_DATA);
    assign rx_pop = rd_stb && (addr == serial_port_pkg::REG_RX_DATA);

    two_entry_buffer tx_buf (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .in_valid(tx_in_valid),
        .in_ready(tx_in_ready),
        .in_data(wr_data[serial_port_pkg::DATA_W-1:0]),
        .out_valid(tx_out_valid),
        .out_ready(tx_take),
        .out_data(tx_out_data),
        .fill()
    );

    two_entry_buffer rx_buf (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .in_valid(s.rx_push),
        .in_ready(rx_in_ready),
        .in_data(s.rx_byte),
        .out_valid(rx_out_valid),
        .out_ready(rx_pop),
        .out_data(rx_out_data),
        .fill(rx_fill)
    );

    always_comb begin
        next_s = s;
        next_s.rx_push = 1'b0;
        next_s.rd_data = '0;

        // three-stage pin synchroniser, a level counts once stages two and three agree
        next_s.s1 = serial_port_pkg::line_type'({rxd, cts, cd});
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        next_s.line = serial_port_pkg::line_type'((s.s2 & s.s3) | (s.line & (s.s2 ^ s.s3)));

        // register writes
        if (wr_stb) begin
            case (addr)
                serial_port_pkg::REG_CONFIG: begin
                    next_s.mode = wr_data[serial_port_pkg::MODE_MSB:0];
                end
                serial_port_pkg::REG_BAUD: begin
                    next_s.bit_cycles = wr_data[15:0];
                end
                serial_port_pkg::REG_MODEM: begin
                    next_s.prog_rts = wr_data[serial_port_pkg::MODEM_RTS];
                    if (eff == serial_port_pkg::MODE_NONE) begin
                        next_s.manual = 1'b1;
                    end
                end
                serial_port_pkg::REG_RTS_DELAY: begin
                    next_s.rts_delay = wr_data[15:0];
                end
                serial_port_pkg::REG_WATERMARK: begin
                    next_s.wm_low = wr_data[serial_port_pkg::WM_LOW_LSB +: 2];
                    next_s.wm_high = wr_data[serial_port_pkg::WM_HIGH_LSB +: 2];
                end
                default: begin
                end
            endcase
        end

        // register reads, data valid only in the cycle after the strobe
        if (rd_stb) begin
            case (addr)
                serial_port_pkg::REG_RX_DATA: begin
                    next_s.rd_data[serial_port_pkg::DATA_W-1:0] = rx_out_valid ? rx_out_data : '0;
                end
                serial_port_pkg::REG_CONFIG: begin
                    next_s.rd_data[serial_port_pkg::MODE_MSB:0] = s.mode;
                end
                serial_port_pkg::REG_BAUD: begin
                    next_s.rd_data[15:0] = s.bit_cycles;
                end
                serial_port_pkg::REG_MODEM: begin
                    next_s.rd_data[serial_port_pkg::MODEM_RTS] = s.rts;
                    next_s.rd_data[serial_port_pkg::MODEM_CTS] = s.line.cts;
                    next_s.rd_data[serial_port_pkg::MODEM_CD] = s.line.cd;
                    next_s.rd_data[serial_port_pkg::MODEM_MANUAL] = s.manual;
                end
                serial_port_pkg::REG_RTS_DELAY: begin
                    next_s.rd_data[15:0] = s.rts_delay;
                end
                serial_port_pkg::REG_WATERMARK: begin
                    next_s.rd_data[serial_port_pkg::WM_LOW_LSB +: 2] = s.wm_low;
                    next_s.rd_data[serial_port_pkg::WM_HIGH_LSB +: 2] = s.wm_high;
                end
                serial_port_pkg::REG_STATUS: begin
                    next_s.rd_data[serial_port_pkg::ST_TX_READY] = tx_in_ready;
                    next_s.rd_data[serial_port_pkg::ST_RX_VALID] = rx_out_valid;
                    next_s.rd_data[serial_port_pkg::ST_TX_BUSY] = (s.tx_state != serial_port_pkg::TX_IDLE);
                    next_s.rd_data[serial_port_pkg::ST_OVERRUN] = s.overrun;
                    next_s.rd_data[serial_port_pkg::ST_FRAME_ERR] = s.frame_err;
                    next_s.rd_data[serial_port_pkg::ST_RX_FILL_LSB +: 2] = rx_fill;
                    next_s.overrun = 1'b0;
                    next_s.frame_err = 1'b0;
                end
                default: begin
                end
            endcase
        end

        // transmitter
        case (s.tx_state)
            serial_port_pkg::TX_IDLE: begin
                next_s.txd = 1'b1;
                if (tx_take) begin
                    next_s.tx_shift = tx_out_data;
                    next_s.tx_cnt = s.bit_cycles - 16'h0001;
                    next_s.tx_bit = '0;
                    next_s.txd = 1'b0;
                    next_s.tx_state = serial_port_pkg::TX_START;
                end
            end
            serial_port_pkg::TX_START: begin
                if (s.tx_cnt == '0) begin
                    next_s.txd = s.tx_shift[0];
                    next_s.tx_cnt = s.bit_cycles - 16'h0001;
                    next_s.tx_state = serial_port_pkg::TX_DATA;
                end else begin
                    next_s.tx_cnt = s.tx_cnt - 16'h0001;
                end
            end
            serial_port_pkg::TX_DATA: begin
                if (s.tx_cnt == '0) begin
                    next_s.tx_cnt = s.bit_cycles - 16'h0001;
                    if (s.tx_bit == serial_port_pkg::BIT_LAST) begin
                        next_s.txd = 1'b1;
                        next_s.tx_state = serial_port_pkg::TX_STOP;
                    end else begin
                        next_s.tx_bit = s.tx_bit + 3'h1;
                        next_s.tx_shift = s.tx_shift >> 1;
                        next_s.txd = s.tx_shift[1];
                    end
                end else begin
                    next_s.tx_cnt = s.tx_cnt - 16'h0001;
                end
            end
            serial_port_pkg::TX_STOP: begin
                if (s.tx_cnt == '0) begin
                    next_s.tx_state = serial_port_pkg::TX_IDLE;
                end else begin
                    next_s.tx_cnt = s.tx_cnt - 16'h0001;
                end
            end
            default: begin
                next_s.tx_state = serial_port_pkg::TX_IDLE;
                next_s.txd = 1'b1;
            end
        endcase

        // receiver, samples at mid-bit
        case (s.rx_state)
            serial_port_pkg::RX_IDLE: begin
                if (!s.line.rxd) begin
                    next_s.rx_cnt = s.bit_cycles >> 1;
                    next_s.rx_bit = '0;
                    next_s.rx_state = serial_port_pkg::RX_START;
                end
            end
            serial_port_pkg::RX_START: begin
                if (s.rx_cnt == '0) begin
                    next_s.rx_cnt = s.bit_cycles - 16'h0001;
                    next_s.rx_state = s.line.rxd ? serial_port_pkg::RX_IDLE : serial_port_pkg::RX_DATA;
                end else begin
                    next_s.rx_cnt = s.rx_cnt - 16'h0001;
                end
            end
            serial_port_pkg::RX_DATA: begin
                if (s.rx_cnt == '0) begin
                    next_s.rx_cnt = s.bit_cycles - 16'h0001;
                    next_s.rx_shift = {s.line.rxd, s.rx_shift[serial_port_pkg::DATA_W-1:1]};
                    next_s.rx_bit = s.rx_bit + 3'h1;
                    if (s.rx_bit == serial_port_pkg::BIT_LAST) begin
                        next_s.rx_state = serial_port_pkg::RX_STOP;
                    end
                end else begin
                    next_s.rx_cnt = s.rx_cnt - 16'h0001;
                end
            end
            serial_port_pkg::RX_STOP: begin
                if (s.rx_cnt == '0) begin
                    next_s.rx_state = serial_port_pkg::RX_IDLE;
                    if (!s.line.rxd) begin
                        next_s.frame_err = 1'b1;
                    end else if (cd_ok) begin
                        next_s.rx_push = 1'b1;
                        next_s.rx_byte = s.rx_shift;
                    end
                end else begin
                    next_s.rx_cnt = s.rx_cnt - 16'h0001;
                end
            end
            default: begin
                next_s.rx_state = serial_port_pkg::RX_IDLE;
            end
        endcase

        // a byte lost to a full receive buffer; set wins over the status-read clear
        if (s.rx_push && !rx_in_ready) begin
            next_s.overrun = 1'b1;
        end

        // automatic RTS: hold while data waits or goes out, then release after the delay
        if (!auto_mode) begin
            next_s.rts_auto = 1'b0;
            next_s.delay_cnt = '0;
        end else if (tx_out_valid || (s.tx_state != serial_port_pkg::TX_IDLE)) begin
            next_s.rts_auto = 1'b1;
            next_s.delay_cnt = ((eff == serial_port_pkg::MODE_AUTO_RTS) || (eff == serial_port_pkg::MODE_FULL_AUTO))
                               ? s.rts_delay : '0;
        end else if (s.rts_auto) begin
            if (s.delay_cnt == '0) begin
                next_s.rts_auto = 1'b0;
            end else begin
                next_s.delay_cnt = s.delay_cnt - 16'h0001;
            end
        end

        // receive watermark hysteresis for the dynamic mode
        if (rx_fill < s.wm_low) begin
            next_s.rts_wm = 1'b1;
        end else if (rx_fill > s.wm_high) begin
            next_s.rts_wm = 1'b0;
        end

        // RTS pin
        case (eff)
            serial_port_pkg::MODE_NONE: begin
                next_s.rts = next_s.rts_auto;
            end
            serial_port_pkg::MODE_MANUAL, serial_port_pkg::MODE_AUTO_CTS: begin
                next_s.rts = next_s.prog_rts;
            end
            serial_port_pkg::MODE_AUTO_RTS, serial_port_pkg::MODE_FULL_AUTO, serial_port_pkg::MODE_ENHANCED: begin
                next_s.rts = next_s.prog_rts | next_s.rts_auto;
            end
            serial_port_pkg::MODE_DYNAMIC: begin
                next_s.rts = next_s.rts_wm;
            end
            default: begin
                next_s.rts = next_s.rts_auto;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= PORT_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign rd_data = s.rd_data;
    assign txd = s.txd;
    assign rts = s.rts;
endmodule // serial_port_flow_control
`default_nettype wire

//--- sp_props.sv
// Purpose: port properties of the serial port
// Assumes: bit period 8; Notes: program rts moves only while idle
`timescale 1ns/1ps
`default_nettype none
module sp_props #(parameter logic [15:0] reset_bit_cycles = 16'h0008) (
    input wire logic sys_clk, arst_n, rd_stb, txd, rts, // bits
    input wire logic [31:0] rd_data); // read data
    logic [6:0] cnt;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // frame position, 0 while idle
    always_ff @(posedge sys_clk or negedge arst_n)
        if (!arst_n) cnt <= 7'h00;
        else if (cnt != 7'h00) cnt <= (cnt == 7'(10 * reset_bit_cycles - 1)) ? 7'h00 : cnt + 7'h01;
        else if (!txd) cnt <= 7'h01;
    a_in_reset: assert property (disable iff (1'b0) !arst_n |=> txd && !rts) else $error("reset");
    a_rd_zero: assert property (!$past(rd_stb) |-> rd_data == 32'h0) else $error("rd");
    a_start_bit: assert property (cnt == 7'h00 && !txd |-> !txd [*8]) else $error("start");
    a_bit_hold: assert property (cnt != 7'h00 && cnt[2:0] != 3'h0 |-> $stable(txd)) else $error("bit");
    a_stop_bit: assert property (cnt == 7'h48 |-> txd [*8]) else $error("stop");
    a_rts_rise: assert property ($rose(rts) |-> cnt == 7'h00 && txd) else $error("rise");
    a_rts_fall: assert property ($fell(rts) |-> cnt == 7'h00 && txd) else $error("fall");
    a_out_idle: assert property ($rose(arst_n) |-> !rts ##1 txd) else $error("idle");
    c_frame: cover property (cnt == 7'h48);
    c_rts: cover property ($rose(rts));
    c_rd: cover property (rd_data != 32'h0);
endmodule // sp_props
bind serial_port_flow_control sp_props #(.reset_bit_cycles(reset_bit_cycles)) u_sp_props (.sys_clk(sys_clk),
    .arst_n(arst_n), .rd_stb(rd_stb), .txd(txd), .rts(rts), .rd_data(rd_data));
`default_nettype wire

//--- dce_model.sv
// Purpose: far side device of the serial line
// Assumes: bit period 8; Notes: no carrier, cts set by the bench
`timescale 1ns/1ps
`default_nettype none
module dce_model (
    input wire logic sys_clk, txd, cts_en, // clock, line in, cts command
    output logic rxd = 1'b1, cts, cd, // line out, handshake
    output logic [7:0] got); // last byte heard
    assign {cts, cd} = {cts_en, 1'b0};
    task send(input logic [7:0] b);
        for (int i = 0; i < 88; i++) @(posedge sys_clk) rxd <= 1'({2'b11, b, 1'b0} >> (i / 8));
    endtask
    // last write of each bit lands mid-bit
    initial forever begin
        @(negedge txd);
        for (int i = 0; i < 68; i++) @(posedge sys_clk) got[(i - 4) / 8] = txd;
    end
endmodule // dce_model
`default_nettype wire

//--- tb.sv
// Purpose: bus level test of the serial port
// Assumes: bit period 8; Notes: waits cover one 80 clock frame
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic sys_clk = 1'b0, arst_n = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, cts_en = 1'b0, rxd, cts, cd, txd, rts;
    logic [7:0] addr = 8'h00, got;
    logic [31:0] wr_data = 32'h0, rd_data;
    int err_total = 0, cmp_count = 0, cyc = 0;
    serial_port_flow_control #(.reset_bit_cycles(16'h0008)) u_serial_port_flow_control (.sys_clk(sys_clk),
        .arst_n(arst_n), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
        .rxd(rxd), .cts(cts), .cd(cd), .txd(txd), .rts(rts));
    dce_model u_dce_model (.sys_clk(sys_clk), .txd(txd), .cts_en(cts_en), .rxd(rxd), .cts(cts), .cd(cd), .got(got));
    initial forever #20 sys_clk = ~sys_clk;
    task chk(input logic [31:0] g, e);
        cmp_count++;
        err_total += int'(g !== e);
        if (g !== e) $display("[ERR] %0t got %h exp %h", $time, g, e);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk) {addr, wr_data, wr_stb} <= {a, d, 1'b1};
        @(posedge sys_clk) wr_stb <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] m, e);
        @(posedge sys_clk) {addr, rd_stb} <= {a, 1'b1};
        @(posedge sys_clk) rd_stb <= 1'b0;
        #1 chk(rd_data & m, e);
    endtask
    task end_sim(input int extra);
        err_total += extra;
        $display("errors %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge sys_clk) if (++cyc == 3000) end_sim(1);
    initial begin
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        rd(8'h08, 32'h7, 32'h0);
        rd(8'h0c, 32'hffff, 32'h8);
        rd(8'hfc, 32'hffffffff, 32'h0);
        wr(8'h00, 32'ha5);
        repeat (90) @(posedge sys_clk);
        #1 chk({16'h0, got, 7'h0, rts}, 32'ha500);
        u_dce_model.send(8'h3c);
        rd(8'h04, 32'hff, 32'h3c);
        wr(8'h08, 32'h2);
        wr(8'h00, 32'h5a);
        repeat (90) @(posedge sys_clk);
        #1 chk(32'(got), 32'ha5);
        @(posedge sys_clk) cts_en <= 1'b1;
        repeat (95) @(posedge sys_clk);
        #1 chk(32'(got), 32'h5a);
        wr(8'h08, 32'h4);
        u_dce_model.send(8'hc3);
        rd(8'h04, 32'hff, 32'h0);
        wr(8'h08, 32'h7);
        wr(8'h10, 32'h1);
        rd(8'h10, 32'hf, 32'hb);
        end_sim(0);
    end
endmodule // tb
`default_nettype wire
